// >>> common/sdc_cfg.svh
// constants for the serial converter input logic
`ifndef SDC_CFG_SVH
`define SDC_CFG_SVH

`define SDC_CODE_W        12
`define SDC_CNT_W         4
`define SDC_CODE_ZERO     12'h000
`define SDC_CNT_ZERO      4'h0
`define SDC_CNT_FULL      4'hC
`define SDC_BUF_W         1
`define SDC_BUF_DEPTH     8
`define SDC_PIN_N         5
`define SDC_PIN_CLK       0
`define SDC_PIN_DATA      1
`define SDC_PIN_SEL       2
`define SDC_PIN_LOAD      3
`define SDC_PIN_CLR       4
`define SDC_PIN_IDLE      5'h1C
`define SDC_CLK_PERIOD_NS 25
`define SDC_LINK_PERIOD_NS 200

`endif

// >>> common/sdc_pkg.sv
// types shared by the serial converter input logic
`include "sdc_cfg.svh"

package sdc_pkg;

    typedef logic [`SDC_CODE_W-1:0] sdc_code_t;
    typedef logic [`SDC_CNT_W-1:0]  sdc_cnt_t;
    typedef logic [`SDC_PIN_N-1:0]  sdc_pins_t;

    typedef enum logic [1:0] {
        SDC_HOLD_LATCHED,
        SDC_HOLD_TRANSPARENT,
        SDC_HOLD_ZEROED
    } sdc_hold_e;

endpackage : sdc_pkg

// >>> logic/sdc_fifo.sv
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps

module sdc_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 8
) (
    // clock and reset
    input  wire logic             ref_clk,
    input  wire logic             rstn,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    logic [AW:0]      next_wr_ptr;
    logic [AW:0]      next_rd_ptr;
    logic             push;
    logic             pop;
    logic             full;
    logic             empty;

    always_comb begin
        empty     = (wr_ptr == rd_ptr);
        full      = (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]) && (wr_ptr[AW] != rd_ptr[AW]);
        in_ready  = !full;
        out_valid = !empty;
        out_data  = mem[rd_ptr[AW-1:0]];
        push      = in_valid && !full;
        pop       = out_ready && !empty;
        next_wr_ptr = push ? wr_ptr + (AW+1)'(1) : wr_ptr;
        next_rd_ptr = pop ? rd_ptr + (AW+1)'(1) : rd_ptr;
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
        end
    end

    // storage needs no reset; empty flag guards reads
    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end

endmodule : sdc_fifo

// >>> logic/sdc_input_logic.sv
// serial input register and holding register of a 12-bit converter
`timescale 1ns/1ps
`include "sdc_cfg.svh"

module sdc_input_logic (
    // clock and reset
    input  wire logic               ref_clk,
    input  wire logic               rstn,
    // serial pins, asynchronous to ref_clk
    input  wire logic               shift_clk,
    input  wire logic               serial_in,
    input  wire logic               select_n,
    input  wire logic               load_strobe_n,
    input  wire logic               zero_clear_n,
    // converter side
    output sdc_pkg::sdc_code_t      dac_code,
    output sdc_pkg::sdc_code_t      shift_word,
    output sdc_pkg::sdc_hold_e      hold_mode,
    // status
    output logic                    word_full,
    output logic                    load_done,
    output logic                    shift_buf_ready,
    output logic                    buf_overrun,
    output logic                    shift_in_load
);
    import sdc_pkg::*;

    function automatic logic rise(input logic cur, input logic prev);
        rise = cur && !prev;
    endfunction : rise

    function automatic logic fall(input logic cur, input logic prev);
        fall = !cur && prev;
    endfunction : fall

    // ---------------- pin synchronisers
    sdc_pins_t pin_raw;
    sdc_pins_t pin_meta;
    sdc_pins_t pin_sync;

    assign pin_raw[`SDC_PIN_CLK]  = shift_clk;
    assign pin_raw[`SDC_PIN_DATA] = serial_in;
    assign pin_raw[`SDC_PIN_SEL]  = select_n;
    assign pin_raw[`SDC_PIN_LOAD] = load_strobe_n;
    assign pin_raw[`SDC_PIN_CLR]  = zero_clear_n;

    localparam sdc_pins_t PIN_IDLE = `SDC_PIN_IDLE;

    genvar gi;
    generate
        for (gi = 0; gi < `SDC_PIN_N; gi++) begin : g_sync
            always_ff @(posedge ref_clk) begin
                if (!rstn) begin
                    pin_meta[gi] <= PIN_IDLE[gi];
                    pin_sync[gi] <= PIN_IDLE[gi];
                end else begin
                    pin_meta[gi] <= pin_raw[gi];
                    pin_sync[gi] <= pin_meta[gi];
                end
            end
        end
    endgenerate

    // ---------------- edge detection
    logic gate;
    logic gate_prev;
    logic load_prev;
    logic next_gate_prev;
    logic next_load_prev;
    logic shift_ev;
    logic load_fall;
    logic load_low;
    logic clr_low;
    logic data_bit;

    // clock and select are interchangeable: the shift edge is a rise of their or
    always_comb begin
        gate           = pin_sync[`SDC_PIN_CLK] | pin_sync[`SDC_PIN_SEL];
        data_bit       = pin_sync[`SDC_PIN_DATA];
        load_low       = !pin_sync[`SDC_PIN_LOAD];
        clr_low        = !pin_sync[`SDC_PIN_CLR];
        shift_ev       = rise(gate, gate_prev);
        load_fall      = fall(pin_sync[`SDC_PIN_LOAD], load_prev);
        next_gate_prev = gate;
        next_load_prev = pin_sync[`SDC_PIN_LOAD];
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            gate_prev <= 1'b1;
            load_prev <= 1'b1;
        end else begin
            gate_prev <= next_gate_prev;
            load_prev <= next_load_prev;
        end
    end

    // ---------------- bit buffer between edge finder and shift register
    logic buf_out_valid;
    logic buf_out_ready;
    logic buf_out_data;

    // draining stalls while load is low so partial data never reaches the output
    assign buf_out_ready = !load_low;

    sdc_fifo #(
        .WIDTH (`SDC_BUF_W),
        .DEPTH (`SDC_BUF_DEPTH)
    ) u_bit_buf (
        .ref_clk   (ref_clk),
        .rstn      (rstn),
        .in_valid  (shift_ev),
        .in_ready  (shift_buf_ready),
        .in_data   (data_bit),
        .out_valid (buf_out_valid),
        .out_ready (buf_out_ready),
        .out_data  (buf_out_data)
    );

    // ---------------- serial input register
    sdc_code_t shreg;
    sdc_code_t next_shreg;
    logic      do_shift;

    always_comb begin
        do_shift   = buf_out_valid && buf_out_ready;
        next_shreg = shreg;
        if (do_shift) begin
            // msb first: older bits move up, oldest falls off the top
            next_shreg = {shreg[`SDC_CODE_W-2:0], buf_out_data};
        end
    end

    // clear leaves this register alone
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            shreg <= `SDC_CODE_ZERO;
        end else begin
            shreg <= next_shreg;
        end
    end

    assign shift_word = shreg;

    // ---------------- bits counted since the last load
    sdc_cnt_t bit_cnt;
    sdc_cnt_t next_bit_cnt;

    always_comb begin
        next_bit_cnt = bit_cnt;
        if (load_fall) begin
            next_bit_cnt = `SDC_CNT_ZERO;
        end else if (do_shift && bit_cnt != `SDC_CNT_FULL) begin
            next_bit_cnt = bit_cnt + `SDC_CNT_W'(1);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            bit_cnt <= `SDC_CNT_ZERO;
        end else begin
            bit_cnt <= next_bit_cnt;
        end
    end

    assign word_full = (bit_cnt == `SDC_CNT_FULL);

    // ---------------- holding register
    sdc_hold_e state;
    sdc_hold_e next_state;
    sdc_code_t hold;
    sdc_code_t next_hold;
    logic      done;
    logic      next_done;

    always_comb begin
        next_state = state;
        next_hold  = hold;
        next_done  = 1'b0;
        if (clr_low) begin
            // clear beats load; no serial edge needed
            next_state = SDC_HOLD_ZEROED;
            next_hold  = `SDC_CODE_ZERO;
        end else begin
            case (state)
                SDC_HOLD_LATCHED: begin
                    if (load_low) begin
                        next_state = SDC_HOLD_TRANSPARENT;
                        next_hold  = next_shreg;
                        next_done  = 1'b1;
                    end
                end
                SDC_HOLD_TRANSPARENT: begin
                    // on release keep the word: the stalled buffer drains in that same cycle
                    if (load_low) begin
                        next_hold  = next_shreg;
                    end else begin
                        next_state = SDC_HOLD_LATCHED;
                    end
                end
                SDC_HOLD_ZEROED: begin
                    // releasing clear with load high keeps zeros
                    if (load_low) begin
                        next_state = SDC_HOLD_TRANSPARENT;
                        next_hold  = next_shreg;
                    end else begin
                        next_state = SDC_HOLD_LATCHED;
                    end
                end
                default: begin
                    next_state = SDC_HOLD_ZEROED;
                    next_hold  = `SDC_CODE_ZERO;
                end
            endcase
        end
    end

    // shifting alone never reaches here while latched
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            state <= SDC_HOLD_ZEROED;
            hold  <= `SDC_CODE_ZERO;
            done  <= 1'b0;
        end else begin
            state <= next_state;
            hold  <= next_hold;
            done  <= next_done;
        end
    end

    assign dac_code  = hold;
    assign hold_mode = state;
    assign load_done = done;

    // ---------------- misuse flags, sticky until reset
    logic overrun;
    logic in_load;
    logic next_overrun;
    logic next_in_load;

    always_comb begin
        next_overrun = overrun || (shift_ev && !shift_buf_ready);
        // controller should not clock data while load is low
        next_in_load = in_load || (shift_ev && load_low);
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            overrun <= 1'b0;
            in_load <= 1'b0;
        end else begin
            overrun <= next_overrun;
            in_load <= next_in_load;
        end
    end

    assign buf_overrun   = overrun;
    assign shift_in_load = in_load;

endmodule : sdc_input_logic

// >>> tb/sdc_host_model.sv
// host controller model driving the serial pins
`timescale 1ns/1ps
module sdc_host_model (
    // clock
    input wire logic ref_clk,
    // serial pins
    output logic     shift_clk,
    output logic     serial_in,
    output logic     select_n,
    output logic     load_strobe_n,
    output logic     zero_clear_n
);
    initial begin
        {shift_clk, serial_in} = 2'h0;
        {select_n, load_strobe_n, zero_clear_n} = 3'h7;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : tick
    task automatic set_ctl(input logic ld, input logic clr);
        @(posedge ref_clk);
        load_strobe_n <= ld;
        zero_clear_n  <= clr;
    endtask : set_ctl
    // one 200 ns link period
    task automatic put_bit(input logic b);
        @(posedge ref_clk);
        shift_clk <= 1'b0;
        serial_in <= b;
        tick(4);
        shift_clk <= 1'b1;
        tick(3);
    endtask : put_bit
    // select rises under a high clock so the clock fall adds no shift
    task automatic put_word(input logic [15:0] w, input int n, input logic sel);
        @(posedge ref_clk);
        select_n <= sel;
        for (int i = n - 1; i >= 0; i--) put_bit(w[i]);
        @(posedge ref_clk);
        select_n  <= 1'b1;
        tick(4);
        shift_clk <= 1'b0;
        serial_in <= ~serial_in;
    endtask : put_word
    task automatic sel_bit(input logic b);
        @(posedge ref_clk);
        select_n  <= 1'b0;
        serial_in <= b;
        tick(4);
        select_n  <= 1'b1;
        tick(4);
        serial_in <= ~b;
    endtask : sel_bit
endmodule : sdc_host_model

// >>> tb/sdc_input_logic_sva.sv
// assertion checker bound to the serial converter input logic
`timescale 1ns/1ps
module sdc_input_logic_sva (
    // clock and reset
    input wire logic               ref_clk,
    input wire logic               rstn,
    // pins and outputs
    input wire logic               select_n,
    input wire logic               load_strobe_n,
    input wire logic               zero_clear_n,
    input wire sdc_pkg::sdc_code_t dac_code,
    input wire sdc_pkg::sdc_code_t shift_word,
    input wire sdc_pkg::sdc_hold_e hold_mode,
    input wire logic               load_done,
    input wire logic               shift_in_load
);
    import sdc_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    sequence s_ld_fall;
        $fell(load_strobe_n) && zero_clear_n && hold_mode == SDC_HOLD_LATCHED;
    endsequence
    sequence s_copied;
        load_done && dac_code == shift_word && hold_mode == SDC_HOLD_TRANSPARENT;
    endsequence
    property p_ld_fall;
        s_ld_fall |-> ##[1:4] s_copied;
    endproperty
    a_ld_fall: assert property (p_ld_fall) else $error("load not taken");
    property p_copy;
        load_done |-> s_copied;
    endproperty
    a_copy: assert property (p_copy) else $error("load copy wrong");
    property p_clr_fall;
        $fell(zero_clear_n) |-> ##[1:5] dac_code == 12'h000;
    endproperty
    a_clr_fall: assert property (p_clr_fall) else $error("clear slow");
    property p_clr_held;
        (!zero_clear_n) [*5] |-> dac_code == 12'h000 && hold_mode == SDC_HOLD_ZEROED;
    endproperty
    a_clr_held: assert property (p_clr_held) else $error("clear not held");
    property p_clr_rise;
        $past(hold_mode) == SDC_HOLD_ZEROED && hold_mode == SDC_HOLD_LATCHED
            |-> dac_code == 12'h000;
    endproperty
    a_clr_rise: assert property (p_clr_rise) else $error("zero not kept");
    property p_latched;
        hold_mode == SDC_HOLD_LATCHED && $past(hold_mode) == SDC_HOLD_LATCHED
            |-> $stable(dac_code);
    endproperty
    a_latched: assert property (p_latched) else $error("latched code moved");
    property p_release;
        hold_mode == SDC_HOLD_LATCHED && $past(hold_mode) == SDC_HOLD_TRANSPARENT
            |-> $stable(dac_code);
    endproperty
    a_release: assert property (p_release) else $error("release moved code");
    // a stalled bit buffer drains late, so stop watching after that
    property p_sel_idle;
        (select_n && load_strobe_n && !shift_in_load) [*8] |-> $stable(shift_word);
    endproperty
    a_sel_idle: assert property (p_sel_idle) else $error("shift while idle");
    property p_step;
        $changed(shift_word) |-> shift_word[11:1] == $past(shift_word[10:0]);
    endproperty
    a_step: assert property (p_step) else $error("shift step wrong");
endmodule : sdc_input_logic_sva

// >>> tb/sdc_input_logic_test.sv
// self-checking bench for the serial converter input logic
`timescale 1ns/1ps
bind sdc_input_logic sdc_input_logic_sva chk_i (.ref_clk(ref_clk), .rstn(rstn),
    .select_n(select_n), .load_strobe_n(load_strobe_n), .zero_clear_n(zero_clear_n),
    .dac_code(dac_code), .shift_word(shift_word), .hold_mode(hold_mode),
    .load_done(load_done), .shift_in_load(shift_in_load));
module sdc_input_logic_test;
    import sdc_pkg::*;
    logic      ref_clk = 1'b0;
    logic      rstn = 1'b0;
    logic      shift_clk, serial_in, select_n, load_strobe_n, zero_clear_n;
    logic      buf_ready, overrun, word_full, in_load;
    sdc_code_t dac_code, shift_word;
    int        n_fail = 0;
    int        samples_checked = 0;
    always #12.5 ref_clk = ~ref_clk;
    sdc_host_model host (.ref_clk(ref_clk), .shift_clk(shift_clk), .serial_in(serial_in),
        .select_n(select_n), .load_strobe_n(load_strobe_n), .zero_clear_n(zero_clear_n));
    sdc_input_logic dut (.ref_clk(ref_clk), .rstn(rstn), .shift_clk(shift_clk),
        .serial_in(serial_in), .select_n(select_n), .load_strobe_n(load_strobe_n),
        .zero_clear_n(zero_clear_n), .dac_code(dac_code), .shift_word(shift_word),
        .hold_mode(), .word_full(word_full), .load_done(), .shift_buf_ready(buf_ready),
        .buf_overrun(overrun), .shift_in_load(in_load));
    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input string name, input sdc_code_t exp, input sdc_code_t got);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    // look just past the edge so the design's own updates have landed
    task automatic pause(input int n);
        host.tick(n);
        #1;
    endtask : pause
    task automatic wait_word(input logic dac, input sdc_code_t exp);
        int i;
        pause(1);
        for (i = 0; i < 40 && (dac ? dac_code : shift_word) !== exp; i++) pause(1);
        chk(dac ? "dac_code" : "shift_word", exp, dac ? dac_code : shift_word);
        if (i == 40) stop_test();
    endtask : wait_word
    task automatic t_word();
        host.put_word(16'h0A5C, 12, 1'b0);
        wait_word(1'b0, 12'hA5C);
        chk("word_full", 12'h001, {11'h000, word_full});
        chk("dac_code", 12'h000, dac_code);
        host.set_ctl(1'b0, 1'b1);
        wait_word(1'b1, 12'hA5C);
        host.set_ctl(1'b1, 1'b1);
        pause(10);
        chk("dac_code", 12'hA5C, dac_code);
        chk("word_full", 12'h000, {11'h000, word_full});
        $display("word test done");
    endtask : t_word
    task automatic t_long();
        host.put_word(16'h2F0F, 14, 1'b0);
        wait_word(1'b0, 12'hF0F);
        chk("word_full", 12'h001, {11'h000, word_full});
        chk("dac_code", 12'hA5C, dac_code);
        host.put_word(16'h0000, 3, 1'b1);
        pause(8);
        chk("shift_word", 12'hF0F, shift_word);
        host.sel_bit(1'b1);
        wait_word(1'b0, 12'hE1F);
        $display("long word test done");
    endtask : t_long
    task automatic t_clear();
        host.set_ctl(1'b1, 1'b0);
        wait_word(1'b1, 12'h000);
        chk("shift_word", 12'hE1F, shift_word);
        host.set_ctl(1'b0, 1'b0);
        pause(8);
        chk("dac_code", 12'h000, dac_code);
        host.set_ctl(1'b1, 1'b0);
        host.set_ctl(1'b1, 1'b1);
        pause(10);
        chk("dac_code", 12'h000, dac_code);
        chk("shift_in_load", 12'h000, {11'h000, in_load});
        $display("clear test done");
    endtask : t_clear
    // shifting under a low load stalls the bit buffer until it refuses
    task automatic t_fill();
        host.set_ctl(1'b0, 1'b1);
        wait_word(1'b1, 12'hE1F);
        host.put_word(16'h03FF, 10, 1'b0);
        pause(4);
        chk("buf_ready", 12'h000, {11'h000, buf_ready});
        chk("overrun", 12'h001, {11'h000, overrun});
        chk("shift_in_load", 12'h001, {11'h000, in_load});
        chk("dac_code", 12'hE1F, dac_code);
        host.set_ctl(1'b1, 1'b1);
        pause(30);
        chk("buf_ready", 12'h001, {11'h000, buf_ready});
        chk("dac_code", 12'hE1F, dac_code);
        chk("shift_word", 12'hFFF, shift_word);
        chk("word_full", 12'h000, {11'h000, word_full});
        $display("fill test done");
    endtask : t_fill
    initial begin
        repeat (8) @(posedge ref_clk);
        rstn <= 1'b1;
        pause(4);
        chk("dac_code", 12'h000, dac_code);
        chk("shift_word", 12'h000, shift_word);
        t_word();
        t_long();
        t_clear();
        t_fill();
        stop_test();
    end
endmodule : sdc_input_logic_test
